/* src/adc_pair_trigger_control.sv */
// Conversion pair trigger control with AHB-Lite register access.
// Assumes one AHB-Lite master, trigger pulses synchronous to hclk,
// and a converter that reports busy and a one-cycle done pulse.
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps

// How it works
// - Selector zero disables pair conversion
// - Codes 1/2 pick individual/global software trigger
// - Codes 01100/11111 pick Timer1/Timer2 match
// - Codes 00011/01101 pick PWM special events
// - Codes 00100..01011 pick PWM primaries 1..8
// - Codes 01111, 10000..10110 pick PWM secondaries
// - Codes 10111..11110 pick current-limit triggers 1..8
// - Completion raises request only when enabled
// - Pending sets on trigger, clears on completion unless a new trigger arrives in that cycle
// - Busy converter: request held until free
module adc_pair_trigger_control (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    input wire logic global_soft_trig, // Shared software trigger
    input wire logic pwm_special, // PWM special event
    input wire logic pwm_sec_special, // PWM secondary special
    input wire logic tmr1_match, // Timer1 period match
    input wire logic tmr2_match, // Timer2 period match
    input wire logic [7:0] pwm_pri, // PWM primary triggers
    input wire logic [8:0] pwm_sec, // PWM secondary triggers
    input wire logic [7:0] pwm_clim, // Current-limit triggers
    input wire logic conv_busy, // Converter resources busy
    input wire logic conv_done, // Pair conversion finished
    output logic conv_start, // Start pair conversion
    output logic pair_irq_req, // Completion request pulse
    output logic irq // Level interrupt
);
    import pair_trig_pkg::*;

    // Bus phase registers
    logic wr_pend_q;
    logic rd_pend_q;
    logic [4:0] addr_q;

    // Control fields
    logic [4:0] sel_q;
    logic irq_en_q;
    logic soft_q;
    logic soft_d;

    // Interrupt status and mask
    logic [STAT_W-1:0] stat_q;
    logic [STAT_W-1:0] stat_d;
    logic [STAT_W-1:0] mask_q;

    // Pair sequencer
    pair_state_t st_q;
    pair_state_t st_d;

    logic trig_hit;

    // Byte offset match shared by all register decodes
    function automatic logic reg_hit(input logic [4:0] a,
        input logic [4:0] off);
        return a == off;
    endfunction

    // Address phase acceptance
    wire take = hsel && hready && htrans[1];
    wire hit_ctrl = reg_hit(addr_q, OFF_CTRL);
    wire hit_stat = reg_hit(addr_q, OFF_STAT);
    wire hit_mask = reg_hit(addr_q, OFF_MASK);
    wire wr_ctrl = wr_pend_q && hit_ctrl;
    wire wr_stat = wr_pend_q && hit_stat;
    wire wr_mask = wr_pend_q && hit_mask;

    // Sequencer status decode
    wire pend = (st_q != ST_IDLE);
    wire pend_set = (st_q == ST_IDLE) && trig_hit;
    wire done_ok = (st_q == ST_CONV) && conv_done;

    // Source selection
    trig_source_mux u_mux (
        .sel(sel_q),
        .soft_trig(soft_q),
        .global_trig(global_soft_trig),
        .pwm_special(pwm_special),
        .pwm_sec_special(pwm_sec_special),
        .tmr1_match(tmr1_match),
        .tmr2_match(tmr2_match),
        .pwm_pri(pwm_pri),
        .pwm_sec(pwm_sec),
        .pwm_clim(pwm_clim),
        .trig(trig_hit)
    );

    // Bus phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 5'h00;
        end else if (hready) begin
            wr_pend_q <= take && hwrite;
            rd_pend_q <= take && !hwrite;
            addr_q <= haddr[4:0];
        end
    end

    // Software trigger: a write set beats the hardware clear
    assign soft_d = (wr_ctrl && hwdata[SWTRG_BIT]) ? 1'b1 :
        (pend_set ? 1'b0 : soft_q);

    // Control register fields
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_q <= SEL_RST;
            irq_en_q <= 1'b0;
            soft_q <= 1'b0;
        end else begin
            soft_q <= soft_d;
            if (wr_ctrl) begin
                sel_q <= hwdata[SEL_MSB:SEL_LSB];
                irq_en_q <= hwdata[IRQEN_BIT];
            end
        end
    end

    // Next state of the pair sequencer
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (trig_hit) begin
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!conv_busy) begin
                    st_d = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_done) begin
                    st_d = trig_hit ? ST_WAIT : ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Start only once resources are free
    assign conv_start = (st_q == ST_WAIT) && !conv_busy;
    assign pair_irq_req = done_ok && irq_en_q;

    // Sticky status, write one to clear, set wins
    always_comb begin
        stat_d = stat_q;
        if (wr_stat) begin
            stat_d = stat_q & ~hwdata[STAT_W-1:0];
        end
        if (pair_irq_req) begin
            stat_d[STAT_DONE_BIT] = 1'b1;
        end
        if (pend_set) begin
            stat_d[STAT_TRIG_BIT] = 1'b1;
        end
    end

    // Status and mask registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= STAT_RST;
            mask_q <= MASK_RST;
        end else begin
            stat_q <= stat_d;
            if (wr_mask) begin
                mask_q <= hwdata[STAT_W-1:0];
            end
        end
    end

    assign irq = |(stat_q & mask_q);

    // Read data; unmapped words read zero
    wire [15:0] ctrl_rd = {3'h0, sel_q, irq_en_q, pend, soft_q, 5'h00};
    assign hrdata = !rd_pend_q ? 32'h0000_0000 :
        hit_ctrl ? {16'h0000, ctrl_rd} :
        hit_stat ? {30'h0000_0000, stat_q} :
        hit_mask ? {30'h0000_0000, mask_q} : 32'h0000_0000;

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Selected trigger moves an idle pair to pending
    a_pend_on_trig: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (st_q == ST_IDLE) && trig_hit |=> pend && stat_q[STAT_TRIG_BIT])
        else $error("pending not set by selected trigger");

    // Completion without a new trigger clears pending
    a_pend_clears: assert property (
        @(posedge hclk) disable iff (!hresetn)
        done_ok && !trig_hit |=> !pend)
        else $error("pending not cleared on completion");

    // Selector zero never starts anything
    a_sel_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (sel_q == SEL_NONE) && (st_q == ST_IDLE) |=> (st_q == ST_IDLE))
        else $error("conversion started with selector zero");

    // Unassigned code behaves as no trigger
    a_code_unused: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (sel_q == 5'h0E) |-> !trig_hit)
        else $error("unassigned code produced a trigger");

    // Software bit starts pair and then self-clears
    a_soft_start: assert property (
        @(posedge hclk) disable iff (!hresetn)
        soft_q && (sel_q == SEL_INDIV) && (st_q == ST_IDLE) && !wr_ctrl
        |=> pend && !soft_q)
        else $error("software trigger mishandled");

    // Software bit ignored under the Timer2 selection
    a_soft_gated: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (sel_q == SEL_TMR2) |-> (trig_hit == tmr2_match))
        else $error("timer2 selection not honoured");

    // Current-limit trigger one follows code 10111
    a_clim_first: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (sel_q == SEL_CLIM_FIRST) |-> (trig_hit == pwm_clim[0]))
        else $error("current-limit mapping wrong");

    // Secondary code 10000 maps to generator three
    a_sec_map: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (sel_q == SEL_SEC_FIRST) |-> (trig_hit == pwm_sec[2]))
        else $error("secondary mapping wrong");

    // Busy converter holds the request
    a_held_busy: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (st_q == ST_WAIT) && conv_busy |-> !conv_start ##1 pend)
        else $error("request lost while busy");

    // Completion request only with enable, and latched
    a_irq_enable: assert property (
        @(posedge hclk) disable iff (!hresetn)
        done_ok |-> (pair_irq_req == irq_en_q)
        ##1 (!$past(irq_en_q) || stat_q[STAT_DONE_BIT]))
        else $error("completion request not gated by enable");

    // Free converter takes a waiting pair next cycle
    a_wait_to_conv: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (st_q == ST_WAIT) && !conv_busy |=> (st_q == ST_CONV))
        else $error("waiting pair not started when free");

    // Pending stays up until completion
    a_pend_holds: assert property (
        @(posedge hclk) disable iff (!hresetn)
        pend && !done_ok |=> pend)
        else $error("pending dropped before completion");

    // Completion status never set with enable low
    a_done_gated: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !irq_en_q && !stat_q[STAT_DONE_BIT] |=> !stat_q[STAT_DONE_BIT])
        else $error("completion status set while disabled");

    // Software bit kept until pending sets
    a_soft_kept: assert property (
        @(posedge hclk) disable iff (!hresetn)
        soft_q && !pend_set |=> soft_q)
        else $error("software bit cleared too early");

    // Code 00010 follows the shared software trigger
    a_global_map: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (sel_q == SEL_GLOBAL) |-> (trig_hit == global_soft_trig))
        else $error("global software mapping wrong");

    // Code 00001 follows only the pair software bit
    a_indiv_map: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (sel_q == SEL_INDIV) |-> (trig_hit == soft_q))
        else $error("individual software mapping wrong");

    // Code 01100 follows the Timer1 match
    a_tmr1_map: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (sel_q == SEL_TMR1) |-> (trig_hit == tmr1_match))
        else $error("timer1 mapping wrong");

    // Code 00011 follows the special event
    a_special_map: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (sel_q == SEL_PWM_SPECIAL) |-> (trig_hit == pwm_special))
        else $error("special event mapping wrong");

    // Code 01101 follows the secondary special event
    a_sec_special: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (sel_q == SEL_PWM_SEC_SPECIAL) |-> (trig_hit == pwm_sec_special))
        else $error("secondary special mapping wrong");

    // Code 00100 follows primary of generator one
    a_pri_first: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (sel_q == SEL_PRI_FIRST) |-> (trig_hit == pwm_pri[0]))
        else $error("first primary mapping wrong");

    // Code 01011 follows primary of generator eight
    a_pri_last: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (sel_q == SEL_PRI_LAST) |-> (trig_hit == pwm_pri[7]))
        else $error("last primary mapping wrong");

    // Code 01111 follows secondary of generator one
    a_sec_gen1: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (sel_q == SEL_SEC_GEN1) |-> (trig_hit == pwm_sec[0]))
        else $error("generator one secondary mapping wrong");

    // Code 10110 follows secondary of generator nine
    a_sec_last: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (sel_q == SEL_SEC_LAST) |-> (trig_hit == pwm_sec[8]))
        else $error("last secondary mapping wrong");

    // Code 11110 follows current limit of generator eight
    a_clim_last: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (sel_q == SEL_CLIM_LAST) |-> (trig_hit == pwm_clim[7]))
        else $error("last current-limit mapping wrong");

endmodule // adc_pair_trigger_control

/* src/pair_trig_pkg.sv */
// Shared constants for the conversion pair trigger control block.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package pair_trig_pkg;

    // Register byte offsets
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_STAT = 5'h04;
    localparam logic [4:0] OFF_MASK = 5'h08;

    // Control register field positions
    localparam int SEL_LSB = 8;
    localparam int SEL_MSB = 12;
    localparam int IRQEN_BIT = 7;
    localparam int PEND_BIT = 6;
    localparam int SWTRG_BIT = 5;

    // Status and mask bit positions
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_TRIG_BIT = 1;
    localparam int STAT_W = 2;

    // Reset values
    localparam logic [4:0] SEL_RST = 5'h00;
    localparam logic [1:0] STAT_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;

    // Trigger source selector codes
    localparam logic [4:0] SEL_NONE = 5'h00;
    localparam logic [4:0] SEL_INDIV = 5'h01;
    localparam logic [4:0] SEL_GLOBAL = 5'h02;
    localparam logic [4:0] SEL_PWM_SPECIAL = 5'h03;
    localparam logic [4:0] SEL_PRI_FIRST = 5'h04;
    localparam logic [4:0] SEL_PRI_LAST = 5'h0B;
    localparam logic [4:0] SEL_TMR1 = 5'h0C;
    localparam logic [4:0] SEL_PWM_SEC_SPECIAL = 5'h0D;
    localparam logic [4:0] SEL_SEC_GEN1 = 5'h0F;
    localparam logic [4:0] SEL_SEC_FIRST = 5'h10;
    localparam logic [4:0] SEL_SEC_LAST = 5'h16;
    localparam logic [4:0] SEL_CLIM_FIRST = 5'h17;
    localparam logic [4:0] SEL_CLIM_LAST = 5'h1E;
    localparam logic [4:0] SEL_TMR2 = 5'h1F;

    // Generator index of first secondary in the 10000 range (gen 3)
    localparam logic [4:0] SEC_IDX_BASE = 5'h02;

    // Pair sequencing states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_CONV = 3'b100
    } pair_state_t;

endpackage

/* src/trig_source_mux.sv */
// Trigger source selector for one conversion pair.
// Assumes all trigger inputs are synchronous to the system clock.
`timescale 1ns/1ps

module trig_source_mux (
    input wire logic [4:0] sel, // Source selector code
    input wire logic soft_trig, // Individual software trigger
    input wire logic global_trig, // Shared software trigger
    input wire logic pwm_special, // PWM special event
    input wire logic pwm_sec_special, // PWM secondary special event
    input wire logic tmr1_match, // Timer1 period match
    input wire logic tmr2_match, // Timer2 period match
    input wire logic [7:0] pwm_pri, // Primary, generators 1..8
    input wire logic [8:0] pwm_sec, // Secondary, generators 1..9
    input wire logic [7:0] pwm_clim, // Current limit, gens 1..8
    output logic trig // Selected trigger
);
    import pair_trig_pkg::*;

    // Range decode of the grouped codes
    wire in_pri = (sel >= SEL_PRI_FIRST) && (sel <= SEL_PRI_LAST);
    wire in_sec = (sel >= SEL_SEC_FIRST) && (sel <= SEL_SEC_LAST);
    wire in_clim = (sel >= SEL_CLIM_FIRST) && (sel <= SEL_CLIM_LAST);

    // Generator indices within each group
    wire [4:0] pri_off = sel - SEL_PRI_FIRST;
    wire [4:0] sec_off = sel - SEL_SEC_FIRST + SEC_IDX_BASE;
    wire [4:0] clim_off = sel - SEL_CLIM_FIRST;
    wire pri_hit = pwm_pri[pri_off[2:0]];
    wire sec_hit = pwm_sec[sec_off[3:0]];
    wire clim_hit = pwm_clim[clim_off[2:0]];

    // Selection; unlisted codes give no trigger
    assign trig = (sel == SEL_INDIV) ? soft_trig :
        (sel == SEL_GLOBAL) ? global_trig :
        (sel == SEL_PWM_SPECIAL) ? pwm_special :
        in_pri ? pri_hit :
        (sel == SEL_TMR1) ? tmr1_match :
        (sel == SEL_PWM_SEC_SPECIAL) ? pwm_sec_special :
        (sel == SEL_SEC_GEN1) ? pwm_sec[0] :
        in_sec ? sec_hit :
        in_clim ? clim_hit :
        (sel == SEL_TMR2) ? tmr2_match :
        1'b0;

endmodule // trig_source_mux

/* test/adc_pair_trigger_control_tb_top.sv */
// Self-checking bench for the pair trigger block.
// Assumes a single AHB-Lite master and the source model beside it.
`timescale 1ns/1ps

module adc_pair_trigger_control_tb_top;
    import pair_trig_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, seed = 32'h50;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, gt, ps, pss, t1, t2, busy, done, start;
    logic ireq, irq, fire = 0, all_src = 0, slow = 1, hold = 0;
    logic [7:0] pri, clim;
    logic [8:0] sec;
    logic [4:0] code = 0;
    int n_fail = 0, samples_checked = 0, n_start = 0, n_req = 0;

    always #2 hclk = ~hclk;

    adc_pair_trigger_control i_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .global_soft_trig(gt), .pwm_special(ps), .pwm_sec_special(pss),
        .tmr1_match(t1), .tmr2_match(t2), .pwm_pri(pri), .pwm_sec(sec),
        .pwm_clim(clim), .conv_busy(busy), .conv_done(done),
        .conv_start(start), .pair_irq_req(ireq), .irq(irq));

    trig_source_model i_src (.hclk(hclk), .hresetn(hresetn), .fire(fire),
        .all_src(all_src), .code(code), .slow(slow), .hold_busy(hold),
        .conv_start(start), .global_soft_trig(gt), .pwm_special(ps),
        .pwm_sec_special(pss), .tmr1_match(t1), .tmr2_match(t2),
        .pwm_pri(pri), .pwm_sec(sec), .pwm_clim(clim), .conv_busy(busy),
        .conv_done(done));

    // Count start and request pulses where they are settled
    always @(negedge hclk) begin
        if (start === 1'b1) n_start++;
        if (ireq === 1'b1) n_req++;
    end

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function logic valid(input logic [4:0] c);
        return c != 5'h00 && c != 5'h01 && c != 5'h0E;
    endfunction

    function logic [31:0] ctrl(input logic [4:0] s, input logic i, p, w);
        return {19'h0, s, i, p, w, 5'h0};
    endfunction

    // One single AHB-Lite transfer, read data kept in rd
    task bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task chk(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task pulse(input logic [4:0] c, input logic a);
        @(posedge hclk);
        fire <= 1'b1;
        code <= c;
        all_src <= a;
        @(posedge hclk);
        fire <= 1'b0;
        all_src <= 1'b0;
    endtask

    task print_verdict;
        $display("checked=%0d failed=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected run of some 1600 cycles
    initial begin
        #80000;
        n_fail++;
        print_verdict;
    end

    // Main sequence
    initial begin
        logic [31:0] r;
        logic v, ien;
        int s0, r0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            bus(32'(i * 4), 1'b0, 32'h0);
            chk(rd, 32'h0);
            chk({31'h0, hresp}, 32'h0);
        end
        bus({27'h0, OFF_MASK}, 1'b1, 32'h3);
        for (int c = 0; c < 32; c++) begin
            r = xs();
            ien = r[0];
            v = valid(5'(c));
            bus({27'h0, OFF_CTRL}, 1'b1, ctrl(5'(c), ien, 1'b0, 1'b0));
            s0 = n_start;
            r0 = n_req;
            pulse((r[5:1] == 5'(c)) ? ~r[5:1] : r[5:1], !v);
            repeat (14) @(posedge hclk);
            chk(32'(n_start - s0), 32'h0);
            if (v) begin
                pulse(5'(c), 1'b0);
                @(posedge hclk);
                bus({27'h0, OFF_CTRL}, 1'b0, 32'h0);
                chk(rd, ctrl(5'(c), ien, 1'b1, 1'b0));
            end
            repeat (16) @(posedge hclk);
            chk(32'(n_start - s0), {31'h0, v});
            chk(32'(n_start - s0), {31'h0, v});
            chk(32'(n_req - r0), {31'h0, v & ien});
            bus({27'h0, OFF_STAT}, 1'b0, 32'h0);
            chk(rd, {30'h0, v, v & ien});
            chk({31'h0, irq}, {31'h0, v});
            bus({27'h0, OFF_STAT}, 1'b1, 32'h3);
            @(posedge hclk);
            chk({31'h0, irq}, 32'h0);
        end
        hold <= 1'b1;
        bus({27'h0, OFF_MASK}, 1'b1, 32'h1);
        s0 = n_start;
        bus({27'h0, OFF_CTRL}, 1'b1, ctrl(5'h01, 1'b0, 1'b0, 1'b0));
        bus({27'h0, OFF_CTRL}, 1'b1, ctrl(5'h01, 1'b0, 1'b0, 1'b1));
        repeat (6) @(posedge hclk);
        chk(32'(n_start - s0), 32'h0);
        bus({27'h0, OFF_CTRL}, 1'b0, 32'h0);
        chk(rd, ctrl(5'h01, 1'b0, 1'b1, 1'b0));
        hold <= 1'b0;
        repeat (16) @(posedge hclk);
        chk(32'(n_start - s0), 32'h1);
        bus({27'h0, OFF_STAT}, 1'b0, 32'h0);
        chk(rd, 32'h2);
        chk({31'h0, irq}, 32'h0);
        bus({27'h0, OFF_STAT}, 1'b1, 32'h3);
        s0 = n_start;
        bus({27'h0, OFF_CTRL}, 1'b1, ctrl(5'h02, 1'b1, 1'b0, 1'b1));
        repeat (8) @(posedge hclk);
        chk(32'(n_start - s0), 32'h0);
        bus({27'h0, OFF_CTRL}, 1'b0, 32'h0);
        chk(rd, ctrl(5'h02, 1'b1, 1'b0, 1'b1));
        print_verdict;
    end
endmodule // adc_pair_trigger_control_tb_top

/* test/trig_source_model.sv */
// Trigger sources and converter standing beside the pair block.
// Assumes commands from the bench arrive by non-blocking assignment.
`timescale 1ns/1ps

module trig_source_model (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset, active low
    input wire logic fire, // Pulse the source of code
    input wire logic all_src, // Pulse every source at once
    input wire logic [4:0] code, // Selector code of the source
    input wire logic slow, // Long conversion when high
    input wire logic hold_busy, // Keep converter busy
    input wire logic conv_start, // Start from the block
    output logic global_soft_trig, // Shared software trigger
    output logic pwm_special, // Special event
    output logic pwm_sec_special, // Secondary special event
    output logic tmr1_match, // Timer1 match
    output logic tmr2_match, // Timer2 match
    output logic [7:0] pwm_pri, // Primary triggers
    output logic [8:0] pwm_sec, // Secondary triggers
    output logic [7:0] pwm_clim, // Current-limit triggers
    output logic conv_busy, // Converter busy
    output logic conv_done // One-cycle completion
);
    logic [31:0] t_q;
    logic [3:0] cnt_q;

    // One trigger line per selector code; gen2 secondary never used
    assign global_soft_trig = t_q[2];
    assign pwm_special = t_q[3];
    assign pwm_pri = t_q[11:4];
    assign tmr1_match = t_q[12];
    assign pwm_sec_special = t_q[13];
    assign pwm_sec = {t_q[22:16], 1'b0, t_q[15]};
    assign pwm_clim = t_q[30:23];
    assign tmr2_match = t_q[31];
    assign conv_busy = hold_busy;

    // Trigger pulses and converter timing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            t_q <= 32'h0;
            cnt_q <= 4'h0;
            conv_done <= 1'b0;
        end else begin
            t_q <= fire ? (all_src ? 32'hFFFFFFFF : 32'h1 << code) : 32'h0;
            conv_done <= (cnt_q == 4'h1);
            if (conv_start) begin
                cnt_q <= slow ? 4'hA : 4'h2;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule // trig_source_model
